// >>> src/link_cfg_ctrl.sv
// external link configuration, credit, error and static forwarding control
//
// Decided for this implementation: the address-and-strobe port.
`default_nettype none
module link_cfg_ctrl
    import link_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    input wire logic [NUM_LINKS-1:0] rx_overflow,
    input wire logic [NUM_LINKS-1:0] rx_illegal,
    input wire logic [NUM_LINKS-1:0] credit_rx,
    input wire logic [NUM_LINKS-1:0] credit_sent,
    input wire logic [NUM_LINKS-1:0] tok_sent,
    input wire logic [NUM_LINKS-1:0] tx_valid,
    input wire logic [NUM_LINKS*8-1:0] tx_data,
    output logic [NUM_LINKS-1:0] tx_ready,
    output logic [NUM_LINKS-1:0] link_enable,
    output logic [NUM_LINKS-1:0] link_wide,
    output logic [NUM_LINKS-1:0] rx_resync,
    output logic [NUM_LINKS-1:0] sym_strobe,
    output logic [NUM_LINKS*8-1:0] sym_token,
    output logic [NUM_LINKS-1:0] tok_done,
    output logic [NUM_LINKS-1:0] static_fwd,
    output logic [NUM_LINKS*CHAN_W-1:0] static_chan
);
    // per-link configuration storage, indexed in link order C,D,B,A,G,H,E,F
    logic [31:0] cfg [NUM_LINKS];
    logic [31:0] next_cfg [NUM_LINKS];
    logic [31:0] stat [NUM_LINKS];
    logic [31:0] next_stat [NUM_LINKS];
    logic [NUM_LINKS-1:0] err, next_err;
    logic [NUM_LINKS-1:0] held, next_held;
    logic [NUM_LINKS-1:0] granted, next_granted;
    logic [NUM_LINKS-1:0] greet, next_greet;
    logic [NUM_LINKS-1:0] resync, next_resync;
    logic [NUM_LINKS-1:0] irq_stat, next_irq_stat;
    logic [NUM_LINKS-1:0] irq_en, next_irq_en;
    logic [31:0] next_rdata;
    logic next_irq;
    logic [NUM_LINKS-1:0] raw_ready;
    logic [NUM_LINKS-1:0] raw_strobe;
    logic [NUM_LINKS-1:0] raw_done;
    logic [NUM_LINKS*8-1:0] raw_token;

    // true when addr falls within the eight-register window at base
    function automatic logic in_bank(input logic [7:0] a,
                                     input logic [7:0] base);
        in_bank = (a[7:3] == base[7:3]);
    endfunction

    function automatic logic [31:0] cfg_view(input logic [31:0] c,
                                             input logic e, input logic g,
                                             input logic h);
        logic [31:0] v;
        v = '0;
        v[BIT_ENABLE] = c[BIT_ENABLE];
        v[BIT_WIDE] = c[BIT_WIDE];
        v[BIT_ERROR] = e;
        v[BIT_GRANTED] = g;
        v[BIT_HELD] = h;
        v[SYM_LSB +: GAP_W] = c[SYM_LSB +: GAP_W];
        v[TOK_LSB +: GAP_W] = c[TOK_LSB +: GAP_W];
        cfg_view = v;
    endfunction

    always_comb begin
        logic [2:0] idx;
        idx = addr[2:0];
        next_err = err | rx_overflow | rx_illegal;
        next_held = held;
        next_granted = granted;
        next_greet = '0;
        next_resync = '0;
        next_irq_stat = irq_stat;
        next_irq_en = irq_en;
        next_rdata = '0;
        for (int i = 0; i < NUM_LINKS; i++) begin
            next_cfg[i] = cfg[i];
            next_stat[i] = stat[i];
            if (credit_rx[i]) begin
                next_held[i] = 1'b1;
            end
            if (credit_sent[i]) begin
                next_granted[i] = 1'b1;
            end
            if (!cfg[i][BIT_ENABLE]) begin
                next_held[i] = 1'b0;
                next_granted[i] = 1'b0;
            end
        end
        if (rd) begin
            if (in_bank(addr, CFG_BASE)) begin
                next_rdata = cfg_view(cfg[idx], err[idx], granted[idx],
                                      held[idx]);
                // a new error in this cycle survives the clear
                next_err[idx] = rx_overflow[idx] | rx_illegal[idx];
            end else if (in_bank(addr, STATIC_BASE)) begin
                next_rdata = stat[idx];
            end else if (addr == IRQ_STATUS_ADDR) begin
                next_rdata = {24'h000000, irq_stat};
            end else if (addr == IRQ_ENABLE_ADDR) begin
                next_rdata = {24'h000000, irq_en};
            end else begin
                next_rdata = UNMAPPED_READ;
            end
        end
        if (wr) begin
            if (in_bank(addr, CFG_BASE)) begin
                next_cfg[idx] = wdata & {1'b1, 1'b1, 8'h00, {2*GAP_W{1'b1}}};
                if (wdata[BIT_INIT]) begin
                    next_held[idx] = 1'b0;
                    next_greet[idx] = wdata[BIT_ENABLE];
                end
                next_resync[idx] = wdata[BIT_RXRST];
            end else if (in_bank(addr, STATIC_BASE)) begin
                next_stat[idx] = '0;
                next_stat[idx][STATIC_EN] = wdata[STATIC_EN];
                next_stat[idx][CHAN_W-1:0] = wdata[CHAN_W-1:0];
            end else if (addr == IRQ_ENABLE_ADDR) begin
                next_irq_en = wdata[NUM_LINKS-1:0];
            end else if (addr == IRQ_CLEAR_ADDR) begin
                next_irq_stat = irq_stat & ~wdata[NUM_LINKS-1:0];
            end
        end
        // set wins over a same-cycle clear
        next_irq_stat = next_irq_stat | rx_overflow | rx_illegal;
        next_irq = |(next_irq_stat & next_irq_en);
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                cfg[i] <= CFG_RESET;
                stat[i] <= STATIC_RESET;
            end
            err <= '0;
            held <= '0;
            granted <= '0;
            greet <= '0;
            resync <= '0;
            irq_stat <= '0;
            irq_en <= '0;
            rdata <= '0;
            irq <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                cfg[i] <= next_cfg[i];
                stat[i] <= next_stat[i];
            end
            err <= next_err;
            held <= next_held;
            granted <= next_granted;
            greet <= next_greet;
            resync <= next_resync;
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
            rdata <= next_rdata;
            irq <= next_irq;
        end
    end

    // pins and static routing follow the stored configuration
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_enable <= '0;
            link_wide <= '0;
            rx_resync <= '0;
            static_fwd <= '0;
            static_chan <= '0;
            sym_strobe <= '0;
            sym_token <= '0;
            tok_done <= '0;
            tx_ready <= '0;
        end else begin
            for (int i = 0; i < NUM_LINKS; i++) begin
                link_enable[i] <= next_cfg[i][BIT_ENABLE];
                link_wide[i] <= next_cfg[i][BIT_WIDE];
                static_fwd[i] <= next_stat[i][STATIC_EN];
                static_chan[i*CHAN_W +: CHAN_W] <=
                    next_stat[i][CHAN_W-1:0];
            end
            rx_resync <= resync;
            sym_strobe <= raw_strobe;
            sym_token <= raw_token;
            tok_done <= raw_done;
            tx_ready <= raw_ready;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_LINKS; g++) begin : g_tx
            link_tx_pacer u_pacer (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .enable(cfg[g][BIT_ENABLE]),
                .wide(cfg[g][BIT_WIDE]),
                .sym_gap(cfg[g][SYM_LSB +: GAP_W]),
                .tok_gap(cfg[g][TOK_LSB +: GAP_W]),
                .credit(held[g] & ~tok_sent[g]),
                .greet(greet[g]),
                .tok_valid(tx_valid[g] & ~raw_ready[g]),
                .tok_data(tx_data[g*8 +: 8]),
                .tok_ready(raw_ready[g]),
                .sym_token(raw_token[g*8 +: 8]),
                .sym_strobe(raw_strobe[g]),
                .tok_done(raw_done[g])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// >>> src/link_cfg_pkg.sv
// constants shared by the external link configuration block
// Notes on behaviour
// - eight link config registers from 0x80, links C,D,B,A,G,H,E,F.
// - bit 31 enables the link and selects shared-port pin muxing.
// - bit 30 picks 2-wire (0) or 5-wire (1) signalling.
// - error bit 27 sets on receive overflow or illegal token encoding.
// - reading the link config register clears the error bit.
// - bit 26 reads one while this end has granted credit to remote.
// - bit 25 reads one while this end holds credit to transmit.
// - bit 24 write clears own credit, sends greeting token if bit 31 is set in the same write, self-clears.
// - bit 23 write resets receiver; next symbol starts a token.
// - bits 21:11 give clocks between transitions inside a token.
// - bits 10:0 give clocks between ends of consecutive tokens.
// - static register bit 31 bypasses routing to one channel end.
// - static register bits 4:0 name the destination channel end.
`default_nettype none
package link_cfg_pkg;
    localparam int NUM_LINKS = 8;
    localparam logic [7:0] CFG_BASE = 8'h80;
    localparam logic [7:0] STATIC_BASE = 8'hA0;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'hC0;
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hC1;
    localparam logic [7:0] IRQ_CLEAR_ADDR = 8'hC2;
    localparam int BIT_ENABLE = 31;
    localparam int BIT_WIDE = 30;
    localparam int BIT_ERROR = 27;
    localparam int BIT_GRANTED = 26;
    localparam int BIT_HELD = 25;
    localparam int BIT_INIT = 24;
    localparam int BIT_RXRST = 23;
    localparam int SYM_LSB = 11;
    localparam int TOK_LSB = 0;
    localparam int GAP_W = 11;
    localparam int STATIC_EN = 31;
    localparam int CHAN_W = 5;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] STATIC_RESET = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    localparam logic [3:0] SYMS_NARROW = 4'h8;
    localparam logic [3:0] SYMS_WIDE = 4'h2;
    localparam logic [7:0] GREETING_TOKEN = 8'hE5;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SYM = 2'b01,
        TX_GAP = 2'b10
    } tx_state_t;
endpackage
`default_nettype wire

// >>> src/link_tx_pacer.sv
// one link's token transmitter pacing: symbol and token spacing
`default_nettype none
module link_tx_pacer
    import link_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic wide,
    input wire logic [GAP_W-1:0] sym_gap,
    input wire logic [GAP_W-1:0] tok_gap,
    input wire logic credit,
    input wire logic greet,
    input wire logic tok_valid,
    input wire logic [7:0] tok_data,
    output logic tok_ready,
    output logic [7:0] sym_token,
    output logic sym_strobe,
    output logic tok_done
);
    tx_state_t state, next_state;
    logic [GAP_W-1:0] cnt, next_cnt;
    logic [3:0] syms, next_syms;
    logic [7:0] tok, next_tok;
    logic pend, next_pend;
    logic next_strobe, next_done, next_ready;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_syms = syms;
        next_tok = tok;
        next_pend = pend | greet;
        next_strobe = 1'b0;
        next_done = 1'b0;
        next_ready = 1'b0;
        if (!enable) begin
            next_state = TX_IDLE;
            next_pend = 1'b0;
        end else begin
            unique case (state)
                TX_IDLE: begin
                    // greeting goes out without credit; data waits
                    if (pend) begin
                        next_tok = GREETING_TOKEN;
                        next_pend = greet;
                        next_state = TX_SYM;
                        next_cnt = '0;
                        next_syms = wide ? SYMS_WIDE : SYMS_NARROW;
                    end else if (tok_valid && credit) begin
                        next_tok = tok_data;
                        next_ready = 1'b1;
                        next_state = TX_SYM;
                        next_cnt = '0;
                        next_syms = wide ? SYMS_WIDE : SYMS_NARROW;
                    end
                end
                TX_SYM: begin
                    if (cnt == '0) begin
                        next_strobe = 1'b1;
                        next_syms = syms - 4'h1;
                        next_cnt = sym_gap;
                        if (syms == 4'h1) begin
                            next_state = TX_GAP;
                            next_done = 1'b1;
                            next_cnt = tok_gap;
                        end
                    end else begin
                        next_cnt = cnt - 1'b1;
                    end
                end
                TX_GAP: begin
                    if (cnt == '0) begin
                        next_state = TX_IDLE;
                    end else begin
                        next_cnt = cnt - 1'b1;
                    end
                end
                default: next_state = TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= TX_IDLE;
            cnt <= '0;
            syms <= '0;
            tok <= '0;
            pend <= 1'b0;
            sym_strobe <= 1'b0;
            tok_done <= 1'b0;
            tok_ready <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            syms <= next_syms;
            tok <= next_tok;
            pend <= next_pend;
            sym_strobe <= next_strobe;
            tok_done <= next_done;
            tok_ready <= next_ready;
        end
    end

    assign sym_token = tok;
endmodule
`default_nettype wire

// >>> verif/link_cfg_ctrl_asserts.sv
// checker for the link configuration block
`default_nettype none
module link_cfg_ctrl_asserts
    import link_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic [NUM_LINKS-1:0] rx_overflow,
    input wire logic [NUM_LINKS-1:0] rx_illegal,
    input wire logic [NUM_LINKS-1:0] link_enable,
    input wire logic [NUM_LINKS-1:0] link_wide,
    input wire logic [NUM_LINKS-1:0] rx_resync,
    input wire logic [NUM_LINKS-1:0] static_fwd,
    input wire logic [NUM_LINKS*CHAN_W-1:0] static_chan
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // a read with no error pulse landing in the same cycle
    sequence quiet_rd;
        rd && addr == CFG_BASE && !rx_overflow[0] && !rx_illegal[0];
    endsequence
    AST_ENABLE_COPY: assert property (wr && addr == CFG_BASE |-> ##1
        link_enable[0] == $past(wdata[BIT_ENABLE]))
        else $error("link enable does not follow bit 31");
    AST_WIDE_COPY: assert property (wr && addr == CFG_BASE |-> ##1
        link_wide[0] == $past(wdata[BIT_WIDE]))
        else $error("link width does not follow bit 30");
    AST_STATIC_COPY: assert property (
        wr && addr == STATIC_BASE |-> ##1
        static_fwd[0] == $past(wdata[STATIC_EN])
        && static_chan[4:0] == $past(wdata[4:0]))
        else $error("static forwarding does not follow its register");
    AST_RESYNC_FIRE: assert property (wr && addr == CFG_BASE
        && wdata[BIT_RXRST] |-> ##2 rx_resync[0])
        else $error("receiver reset not issued");
    AST_RESYNC_PULSE: assert property (
        rx_resync[0]
        && !$past(wr && addr == CFG_BASE && wdata[BIT_RXRST])
        |=> !rx_resync[0])
        else $error("receiver reset does not clear itself");
    AST_WO_READ_ZERO: assert property (
        rd && addr == CFG_BASE |=>
        rdata[29:28] == 2'h0 && rdata[24:22] == 3'h0)
        else $error("reserved or write-only bits read nonzero");
    AST_ERR_SET: assert property ((rx_overflow[0] || rx_illegal[0])
        ##1 !rd ##1 (rd && addr == CFG_BASE) |=> rdata[BIT_ERROR])
        else $error("error flag missing after receive fault");
    AST_ERR_CLEAR: assert property (quiet_rd
        ##1 (!rd && !rx_overflow[0] && !rx_illegal[0]) ##1 quiet_rd
        |=> !rdata[BIT_ERROR])
        else $error("error flag survives a read");
    cover property (rx_resync[0]);
    cover property (wr && addr == STATIC_BASE ##2 static_fwd[0]);
    cover property (rx_overflow[0] ##2 rd);
endmodule
bind link_cfg_ctrl link_cfg_ctrl_asserts u_chk (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_overflow(rx_overflow), .rx_illegal(rx_illegal),
    .link_enable(link_enable), .link_wide(link_wide),
    .rx_resync(rx_resync), .static_fwd(static_fwd),
    .static_chan(static_chan));
`default_nettype wire

// >>> verif/remote_link_model.sv
// remote link end model: answers greeting tokens with credit
`default_nettype none
module remote_link_model
    import link_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] sym_token,
    input wire logic tok_done,
    input wire logic slow,
    output logic credit_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] wait_cnt;
    // slow mode stands for a remote busy draining its own receiver
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_cnt <= 6'h00;
            credit_rx <= 1'b0;
        end else begin
            credit_rx <= (wait_cnt == 6'h01);
            if (tok_done && sym_token == GREETING_TOKEN) begin
                wait_cnt <= slow ? 6'h1E : 6'h03;
            end else if (wait_cnt != 6'h00) begin
                wait_cnt <= wait_cnt - 6'h01;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the link configuration block
`default_nettype none
module tb_top
    import link_cfg_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, slow = 1'b0;
    logic [7:0] addr = 8'h00, ovf = 8'h00, ill = 8'h00, cr_sent = 8'h00;
    logic [7:0] tsent = 8'h00;
    logic [7:0] txv = 8'h00, tx_ready, link_enable, link_wide, rx_resync;
    logic [7:0] sym_strobe, tok_done, static_fwd, cr_rx;
    logic [31:0] wdata = 32'h0000_0000, rdata, rv;
    logic [63:0] txd = 64'h0, sym_token;
    logic [39:0] static_chan;
    logic irq, cr0;
    int n_fail = 0, cmp_count = 0;
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
    always #2 ref_clk = ~ref_clk;
    assign cr_rx = {7'h00, cr0};
    link_cfg_ctrl u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .rx_overflow(ovf), .rx_illegal(ill), .credit_rx(cr_rx),
        .credit_sent(cr_sent), .tok_sent(tsent), .tx_valid(txv),
        .tx_data(txd), .tx_ready(tx_ready), .link_enable(link_enable),
        .link_wide(link_wide), .rx_resync(rx_resync),
        .sym_strobe(sym_strobe), .sym_token(sym_token),
        .tok_done(tok_done), .static_fwd(static_fwd),
        .static_chan(static_chan));
    remote_link_model u_remote (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .sym_token(sym_token[7:0]), .tok_done(tok_done[0]), .slow(slow),
        .credit_rx(cr0));
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        rv = rdata;
        `CHK(rv & m, e)
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // one-cycle pulse on link 0: 0 overflow, 1 illegal, 2 credit granted
    task automatic pulse(input int k);
        @(posedge ref_clk);
        ovf <= {7'h00, k == 0};
        ill <= {7'h00, k == 1};
        cr_sent <= {7'h00, k == 2};
        @(posedge ref_clk);
        ovf <= 8'h00;
        ill <= 8'h00;
        cr_sent <= 8'h00;
    endtask
    task automatic t_regs;
        chk_rd(CFG_BASE, 32'hFFFF_FFFF, CFG_RESET);
        wr_reg(8'h90, 32'hFFFF_FFFF);
        chk_rd(8'h90, 32'hFFFF_FFFF, UNMAPPED_READ);
        for (int i = 0; i < 8; i++) begin
            wr_reg(CFG_BASE + 8'(i), 32'hB640_0000);
            wr_reg(STATIC_BASE + 8'(i), {27'h7FF_FFFF, 5'(i + 8)});
        end
        wt(3);
        `CHK(link_enable, 8'hFF)
        `CHK(static_fwd, 8'hFF)
        for (int i = 0; i < 8; i++) begin
            `CHK(static_chan[i*5+:5], 5'(i + 8))
            chk_rd(CFG_BASE + 8'(i), 32'hFFFF_FFFF, 32'h8000_0000);
            chk_rd(STATIC_BASE + 8'(i), 32'hFFFF_FFFF,
                   32'h8000_0000 | 32'(i + 8));
            wr_reg(CFG_BASE + 8'(i), 32'h0000_0000);
            wr_reg(STATIC_BASE + 8'(i), 32'h0000_0000);
        end
        wt(3);
        `CHK({link_enable, static_fwd}, 16'h0000)
    endtask
    task automatic t_err;
        wr_reg(IRQ_ENABLE_ADDR, 32'h0000_0001);
        pulse(0);
        wt(3);
        `CHK(irq, 1'b1)
        chk_rd(IRQ_STATUS_ADDR, 32'h0000_0001, 32'h0000_0001);
        wr_reg(IRQ_CLEAR_ADDR, 32'h0000_0001);
        wt(3);
        `CHK(irq, 1'b0)
        wr_reg(IRQ_ENABLE_ADDR, 32'h0000_0000);
        pulse(1);
        chk_rd(CFG_BASE, 32'h0800_0000, 32'h0800_0000);
        chk_rd(CFG_BASE, 32'h0800_0000, 32'h0000_0000);
        `CHK(irq, 1'b0)
        wr_reg(CFG_BASE, 32'h8000_0000);
        pulse(2);
        chk_rd(CFG_BASE, 32'h0400_0000, 32'h0400_0000);
    endtask
    task automatic t_resync;
        int n;
        n = 0;
        wr_reg(CFG_BASE, 32'h8080_0000);
        for (int k = 0; k < 6; k++) begin
            @(negedge ref_clk);
            n += int'(rx_resync[0]);
        end
        `CHK(n, 1)
        chk_rd(CFG_BASE, 32'h0180_0000, 32'h0000_0000);
    endtask
    // greeting, then two data tokens that wait for the remote's credit
    task automatic t_tok(input logic w, input logic sl);
        int n, r, last, s;
        n = 0;
        r = 0;
        last = 0;
        s = w ? 2 : 8;
        slow = sl;
        wr_reg(CFG_BASE, 32'h0000_0000);
        txd <= 64'h3C;
        txv <= 8'h01;
        wr_reg(CFG_BASE, {1'b1, w, 6'h01, 2'h0, 11'd2, 11'd3});
        for (int k = 0; k < 300; k++) begin
            @(posedge ref_clk);
            if (r == 2) txv <= 8'h00;
            @(negedge ref_clk);
            r += int'(tx_ready[0]);
            if (sym_strobe[0]) begin
                if (n % s != 0) `CHK(k - last, 3)
                else if (n > 0) `CHK(k - last > 4, 1'b1)
                last = k;
                n++;
            end
            if (tok_done[0])
                `CHK(sym_token[7:0],
                    n == s ? GREETING_TOKEN : 8'h3C)
        end
        `CHK(n, 3 * s)
        `CHK(link_wide[0], w)
        chk_rd(CFG_BASE, 32'h0200_0000, 32'h0200_0000);
    endtask
    // credit spent this cycle: a waiting token may start only once it clears
    task automatic t_block;
        int n;
        n = 0;
        @(posedge ref_clk);
        tsent <= 8'h01;
        txv <= 8'h01;
        repeat (40) begin
            @(negedge ref_clk);
            n += int'(sym_strobe[0]);
        end
        `CHK(n, 0)
        @(posedge ref_clk);
        tsent <= 8'h00;
        n = 0;
        repeat (8) begin
            @(negedge ref_clk);
            n += int'(tx_ready[0]);
        end
        `CHK(n, 1)
        @(posedge ref_clk);
        txv <= 8'h00;
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs;
        t_err;
        t_resync;
        t_tok(1'b0, 1'b0);
        t_block;
        t_tok(1'b1, 1'b1);
        tally_and_finish;
    end
    // whole run is under a thousand cycles; this leaves ample margin
    initial begin
        #200000;
        n_fail++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
